/* File: design/odscl_core.v */
// Purpose: SPI command logic of an eight-channel high-side/push-pull driver
// Assumes: SPI mode with data sampled on rising and shifted on falling clock
// Notes:   Link pins are oversampled by ref_clk through three-stage syncs
`timescale 1ns/10ps
`include "odscl_map.vh"
module odscl_core #(
   parameter STRETCH_CYC   = `ODSCL_STRETCH_CYC,
   parameter PAR_CFG_ALLOW = 1
) (
   input  wire       ref_clk,
   input  wire       resetn,
   input  wire       spi_sclk,
   input  wire       spi_csn,
   input  wire       spi_mosi,
   output reg        spi_miso,
   input  wire       serial_setting_select,
   input  wire       command_select,
   input  wire       setup_select,
   input  wire       long_word_select,
   input  wire       open_load_pin,
   input  wire [7:0] in_pins,
   input  wire [7:0] thermal_trip,
   input  wire [7:0] open_load_det,
   input  wire [7:0] above_7v,
   input  wire [7:0] slow_mode,
   input  wire [7:0] above_supply_flag,
   input  wire [7:0] global_fault_in,
   input  wire [7:0] short_circuit,
   input  wire       check_error,
   output reg  [7:0] high_switch,
   output reg  [7:0] low_switch,
   output reg  [7:0] pushpull_select,
   output reg  [7:0] open_load_enable,
   output reg  [1:0] watchdog_period,
   output reg  [1:0] channel_coupling,
   output reg        clock_count_error,
   output reg        fault_n
);
   // ----------------------------------------------------------------------
   // Pin synchronisers
   // ----------------------------------------------------------------------
   reg  [2:0] sclk_s_r;
   reg  [2:0] csn_s_r;
   reg  [2:0] mosi_s_r;
   reg        sclk_q_r;
   reg        csn_q_r;
   reg        mosi_q_r;
   // A level counts only once stages two and three agree
   always @(posedge ref_clk) begin
      if (!resetn) begin
         sclk_s_r <= 3'h0;
         sclk_q_r <= 1'b0;
      end else begin
         sclk_s_r <= {sclk_s_r[1:0], spi_sclk};
         if (sclk_s_r[1] == sclk_s_r[2])
            sclk_q_r <= sclk_s_r[2];
      end
   end

   always @(posedge ref_clk) begin
      if (!resetn) begin
         csn_s_r <= 3'h7;
         csn_q_r <= 1'b1;
      end else begin
         csn_s_r <= {csn_s_r[1:0], spi_csn};
         if (csn_s_r[1] == csn_s_r[2])
            csn_q_r <= csn_s_r[2];
      end
   end

   always @(posedge ref_clk) begin
      if (!resetn) begin
         mosi_s_r <= 3'h0;
         mosi_q_r <= 1'b0;
      end else begin
         mosi_s_r <= {mosi_s_r[1:0], spi_mosi};
         if (mosi_s_r[1] == mosi_s_r[2])
            mosi_q_r <= mosi_s_r[2];
      end
   end
   wire sclk_new = (sclk_s_r[1] == sclk_s_r[2]) ? sclk_s_r[2] : sclk_q_r;
   wire csn_new  = (csn_s_r[1] == csn_s_r[2]) ? csn_s_r[2] : csn_q_r;
   wire sclk_rise = sclk_new & ~sclk_q_r;
   wire sclk_fall = ~sclk_new & sclk_q_r;
   wire cs_fall   = ~csn_new & csn_q_r;
   wire cs_rise   = csn_new & ~csn_q_r;
   wire in_frame  = ~csn_q_r;

   // ----------------------------------------------------------------------
   // Fault stretching
   // ----------------------------------------------------------------------
   // One counter per stretched source keeps short blips visible to readback
   wire [7:0] th_str;
   wire [7:0] ol_str;
   wire       tg_str;
   genvar g;
   generate
      for (g = 0; g < 17; g = g + 1) begin : g_str
         reg [31:0] cnt_r;
         wire       src;
         if (g < 8) begin : g_t
            assign src = thermal_trip[g];
            assign th_str[g] = src | (cnt_r != 32'h0000_0000);
         end else if (g < 16) begin : g_o
            assign src = open_load_det[g-8];
            assign ol_str[g-8] = src | (cnt_r != 32'h0000_0000);
         end else begin : g_g
            assign src = global_fault_in[3];
            assign tg_str = src | (cnt_r != 32'h0000_0000);
         end
         always @(posedge ref_clk) begin
            if (!resetn)
               cnt_r <= 32'h0000_0000;
            else if (src)
               cnt_r <= STRETCH_CYC;
            else if (cnt_r != 32'h0000_0000)
               cnt_r <= cnt_r - 32'h0000_0001;
         end
      end
   endgenerate

   // ----------------------------------------------------------------------
   // Real-time status
   // ----------------------------------------------------------------------
   wire [7:0] alarm_rt = th_str | ol_str;
   wire [7:0] level_rt = setup_select ? slow_mode : above_7v;
   wire [7:0] glob_rt  = {global_fault_in[7], check_error,
                          global_fault_in[5], clock_count_error,
                          tg_str, global_fault_in[2:0]};

   // ----------------------------------------------------------------------
   // Registers
   // ----------------------------------------------------------------------
   reg  [7:0]  out_set_r;
   reg  [7:0]  mode_r;
   reg  [7:0]  olen_r;
   reg  [7:0]  cfg_r;
   reg  [7:0]  ol_lat_r;
   reg  [7:0]  th_lat_r;
   reg  [7:0]  gl_lat_r;
   reg         fault_lat_r;
   reg  [15:0] rx_r;
   reg  [15:0] tx_r;
   reg  [15:0] resp_r;
   reg  [4:0]  bitcnt_r;
   reg  [7:0]  prev_th_r;
   reg  [7:0]  prev_ol_r;
   reg  [7:0]  prev_gl_r;
   reg  [7:0]  dir_out_r;
   reg  [7:0]  dir_pp_r;
   reg  [7:0]  dir_ol_r;

   // ----------------------------------------------------------------------
   // Frame decode
   // ----------------------------------------------------------------------
   wire       serial_cmd = serial_setting_select & command_select;
   wire       cfg_ok = serial_setting_select | (PAR_CFG_ALLOW != 0);
   // A frame with no clocks at all is refused as well
   wire       frame_ok = (bitcnt_r[2:0] == 3'h0) && (bitcnt_r != 5'h00)
                         && !check_error;
   wire [6:0] cmd = rx_r[14:8];
   wire [7:0] dat = rx_r[7:0];
   wire       zclr = rx_r[15] & command_select;

   // Response for the command just received, sent in the next frame
   reg  [15:0] resp_nxt;
   always @* begin
      resp_nxt = {alarm_rt, level_rt};
      if (cmd == `ODSCL_CMD_READ) begin
         case (dat[2:0])
            `ODSCL_REG_OUT:   resp_nxt = {8'h00, out_set_r};
            `ODSCL_REG_MODE:  resp_nxt = {8'h00, mode_r};
            `ODSCL_REG_OLEN:  resp_nxt = {8'h00, olen_r};
            `ODSCL_REG_CFG:   resp_nxt = {8'h00, cfg_r};
            `ODSCL_REG_OLLAT: resp_nxt = {ol_str, ol_lat_r};
            `ODSCL_REG_THLAT: resp_nxt = {th_str, th_lat_r};
            `ODSCL_REG_GLLAT: resp_nxt = {glob_rt, gl_lat_r};
            default:          resp_nxt = {above_supply_flag, 8'h00};
         endcase
      end
   end

   // ----------------------------------------------------------------------
   // Driver steering terms
   // ----------------------------------------------------------------------
   wire       sc_alarm = |short_circuit & ~cfg_r[`ODSCL_CFG_SCOFF];
   wire [7:0] alarm_fault = alarm_rt | {7'h00, sc_alarm | tg_str};
   wire [7:0] drive = serial_setting_select
                      ? (command_select ? out_set_r : dir_out_r)
                      : in_pins;
   wire [7:0] pp_eff = command_select ? mode_r : dir_pp_r;
   wire [7:0] ol_dir = dir_ol_r | (open_load_pin ? ~dir_pp_r : 8'h00);
   wire [7:0] ol_eff = command_select ? olen_r : ol_dir;
   wire       couple = cfg_r[`ODSCL_CFG_JUP] & cfg_r[`ODSCL_CFG_JDN];
   wire       cfg_upd = cfg_ok | ~command_select;
   // Low switch follows the mode of the same cycle, never a stale one
   wire [7:0] pp_nxt = cfg_upd ? (couple ? 8'h00 : pp_eff)
                               : pushpull_select;
   wire       dir_word = frame_ok && serial_setting_select
                         && !command_select && (bitcnt_r == 5'h10);

   // ----------------------------------------------------------------------
   // Link shifter
   // ----------------------------------------------------------------------
   always @(posedge ref_clk) begin
      if (!resetn) begin
         rx_r     <= 16'h0000;
         tx_r     <= 16'h0000;
         bitcnt_r <= 5'h00;
         spi_miso <= 1'b0;
      end else begin
         // Status is captured at frame start; with command_select high it was captured at the previous frame end
         if (cs_fall) begin
            bitcnt_r <= 5'h00;
            tx_r     <= command_select ? resp_r
                                       : {alarm_rt, level_rt};
            spi_miso <= command_select ? resp_r[15] : alarm_rt[7];
         end else if (in_frame && sclk_rise) begin
            rx_r <= {rx_r[14:0], mosi_q_r};
            if (bitcnt_r != 5'h1F)
               bitcnt_r <= bitcnt_r + 5'h01;
         end else if (in_frame && sclk_fall && bitcnt_r != 5'h00) begin
            tx_r     <= {tx_r[14:0], 1'b0};
            spi_miso <= tx_r[14];
         end
      end
   end

   // ----------------------------------------------------------------------
   // Latched faults
   // ----------------------------------------------------------------------
   // A new event in the clearing cycle wins over the clear
   always @(posedge ref_clk) begin
      if (!resetn) begin
         ol_lat_r    <= 8'h00;
         th_lat_r    <= 8'h00;
         gl_lat_r    <= 8'h00;
         fault_lat_r <= 1'b0;
         prev_th_r   <= 8'h00;
         prev_ol_r   <= 8'h00;
         prev_gl_r   <= 8'h00;
      end else begin
         prev_th_r <= th_str;
         prev_ol_r <= ol_str;
         prev_gl_r <= glob_rt;
         if (cs_rise && zclr && frame_ok) begin
            ol_lat_r    <= ol_str & ~prev_ol_r;
            th_lat_r    <= th_str & ~prev_th_r;
            gl_lat_r    <= glob_rt & ~prev_gl_r;
            fault_lat_r <= |alarm_fault;
         end else begin
            ol_lat_r    <= ol_lat_r | (ol_str & ~prev_ol_r);
            th_lat_r    <= th_lat_r | (th_str & ~prev_th_r);
            gl_lat_r    <= gl_lat_r | (glob_rt & ~prev_gl_r);
            if (|alarm_fault)
               fault_lat_r <= 1'b1;
         end
      end
   end

   // ----------------------------------------------------------------------
   // Command registers
   // ----------------------------------------------------------------------
   always @(posedge ref_clk) begin
      if (!resetn) begin
         out_set_r         <= `ODSCL_RST_BYTE;
         mode_r            <= `ODSCL_RST_BYTE;
         olen_r            <= `ODSCL_RST_BYTE;
         cfg_r             <= `ODSCL_RST_BYTE;
         resp_r            <= 16'h0000;
         clock_count_error <= 1'b0;
      end else if (cs_rise) begin
         clock_count_error <= (bitcnt_r[2:0] != 3'h0);
         if (frame_ok && command_select) begin
            resp_r <= resp_nxt;
            case (cmd)
               `ODSCL_CMD_OUT:  out_set_r <= dat;
               `ODSCL_CMD_MODE: mode_r <= dat;
               `ODSCL_CMD_OLEN: olen_r <= dat;
               `ODSCL_CMD_CFG:
                  cfg_r <= dat & `ODSCL_CFG_MASK;
               default: ;
            endcase
         end
      end
   end

   // ----------------------------------------------------------------------
   // Direct-mode registers
   // ----------------------------------------------------------------------
   // Channel code with setup_select low: drive bit in the high byte, mode bit in the low byte
   always @(posedge ref_clk) begin
      if (!resetn) begin
         dir_out_r <= 8'h00;
         dir_pp_r  <= 8'h00;
         dir_ol_r  <= 8'h00;
      end else if (cs_rise && dir_word) begin
         if (!setup_select) begin
            dir_out_r <= rx_r[15:8];
            dir_pp_r  <= rx_r[7:0];
         end else begin
            dir_pp_r <= ~rx_r[15:8] & rx_r[7:0];
            dir_ol_r <= rx_r[15:8] & ~rx_r[7:0];
         end
      end
   end

   // ----------------------------------------------------------------------
   // Driver outputs
   // ----------------------------------------------------------------------
   always @(posedge ref_clk) begin
      if (!resetn) begin
         high_switch <= 8'h00;
         low_switch  <= 8'h00;
         fault_n     <= 1'b1;
      end else begin
         high_switch <= drive & ~th_str;
         low_switch  <= ~drive & pp_nxt & ~th_str;
         fault_n <= serial_cmd ? ~fault_lat_r
                               : ~((|alarm_fault) | clock_count_error);
      end
   end

   // ----------------------------------------------------------------------
   // Configuration outputs
   // ----------------------------------------------------------------------
   always @(posedge ref_clk) begin
      if (!resetn) begin
         pushpull_select  <= 8'h00;
         open_load_enable <= 8'h00;
         watchdog_period  <= 2'h0;
         channel_coupling <= 2'h0;
      end else if (cfg_upd) begin
         pushpull_select  <= pp_nxt;
         open_load_enable <= ol_eff;
         watchdog_period  <= cfg_r[1:0];
         channel_coupling <= cfg_r[3:2];
      end
   end
endmodule // odscl_core

/* File: design/odscl_map.vh */
// Purpose: Register offsets, field positions, reset values and timing counts
// Assumes: 20 MHz reference clock
// Notes:   Definitions only
`ifndef ODSCL_MAP_VH
`define ODSCL_MAP_VH
// ----------------------------------------------------------------------
// Register indices
// ----------------------------------------------------------------------
`define ODSCL_REG_OUT      3'h0
`define ODSCL_REG_MODE     3'h1
`define ODSCL_REG_OLEN     3'h2
`define ODSCL_REG_CFG      3'h3
`define ODSCL_REG_OLLAT    3'h4
`define ODSCL_REG_THLAT    3'h5
`define ODSCL_REG_GLLAT    3'h6
`define ODSCL_REG_ABOVE    3'h7
// ----------------------------------------------------------------------
// Commands (low seven bits of the command byte)
// ----------------------------------------------------------------------
`define ODSCL_CMD_OUT      7'h00
`define ODSCL_CMD_MODE     7'h01
`define ODSCL_CMD_OLEN     7'h02
`define ODSCL_CMD_CFG      7'h03
`define ODSCL_CMD_READ     7'h20
`define ODSCL_CMD_STATUS   7'h30
// ----------------------------------------------------------------------
// Fields and reset values
// ----------------------------------------------------------------------
`define ODSCL_CFG_MASK     8'h1F
`define ODSCL_CFG_SCOFF    4
`define ODSCL_CFG_JUP      3
`define ODSCL_CFG_JDN      2
`define ODSCL_GL_CKERR     4
`define ODSCL_GL_CRC       6
`define ODSCL_RST_BYTE     8'h00
`define ODSCL_CODE_PP      2'h1
`define ODSCL_CODE_OL      2'h2
// ----------------------------------------------------------------------
// Timing
// ----------------------------------------------------------------------
`define ODSCL_CLK_HZ       20000000
`define ODSCL_STRETCH_MS   200
`define ODSCL_STRETCH_CYC  (`ODSCL_CLK_HZ / 1000 * `ODSCL_STRETCH_MS)
`endif

/* File: sim/odscl_monitor.sv */
// Purpose: Port-level checks of the SPI command logic
// Assumes: Link pins are sampled by ref_clk inside the design
// Notes:   Bound to odscl_core below the module
`timescale 1ns/10ps
module odscl_monitor #(
   parameter STRETCH_CYC = 20
) (
   input wire       ref_clk,
   input wire       resetn,
   input wire       spi_csn,
   input wire       serial_setting_select,
   input wire       command_select,
   input wire [7:0] in_pins,
   input wire [7:0] thermal_trip,
   input wire [7:0] global_fault_in,
   input wire [7:0] high_switch,
   input wire [7:0] low_switch,
   input wire [7:0] pushpull_select,
   input wire [1:0] watchdog_period,
   input wire       clock_count_error,
   input wire       fault_n
);
   default clocking cb @(posedge ref_clk);
   endclocking
   default disable iff (!resetn);
   // ----------
   // Sequences
   // ----------
   // Thermal events may force switches off, so they void the follow check
   sequence pins_steady_s;
      (!serial_setting_select && $stable(in_pins)
       && ~|{thermal_trip, global_fault_in})[*4];
   endsequence
   sequence cs_high_s;
      spi_csn && $past(spi_csn, 3);
   endsequence
   hs_ls_excl_a: assert property (
      (high_switch & low_switch) == 8'h00)
      else $error("high and low switch on together");
   low_pp_only_a: assert property (
      (low_switch & ~pushpull_select) == 8'h00)
      else $error("low switch on outside push-pull");
   par_follow_a: assert property (
      pins_steady_s |-> high_switch == in_pins)
      else $error("outputs do not follow parallel pins");
   mode_at_cs_a: assert property (
      $changed(pushpull_select) |-> cs_high_s)
      else $error("mode changed inside a frame");
   wdog_at_cs_a: assert property (
      $changed(watchdog_period) |-> spi_csn)
      else $error("watchdog period changed inside a frame");
   cke_at_cs_a: assert property (
      $changed(clock_count_error) |-> cs_high_s)
      else $error("count error flag moved inside a frame");
   alarm_rise_a: assert property (
      thermal_trip != 8'h00 |-> ##[1:8] !fault_n)
      else $error("alarm output missed a thermal event");
   latch_hold_a: assert property (
      serial_setting_select && command_select
      && $stable({serial_setting_select, command_select})
      && $rose(fault_n) |-> cs_high_s)
      else $error("latched alarm released outside frame end");
endmodule // odscl_monitor
bind odscl_core odscl_monitor #(.STRETCH_CYC(STRETCH_CYC)) odscl_monitor_inst (
   .ref_clk, .resetn, .spi_csn, .serial_setting_select, .command_select,
   .in_pins, .thermal_trip, .global_fault_in, .high_switch, .low_switch,
   .pushpull_select, .watchdog_period, .clock_count_error, .fault_n);

/* File: sim/odscl_spi_host.sv */
// Purpose: SPI host model for the command logic
// Assumes: Clock idles low, data MSB first, 400 ns bit period
// Notes:   Frame start is offset from ref_clk to keep phases unrelated
`timescale 1ns/10ps
module odscl_spi_host (
   output logic spi_sclk,
   output logic spi_csn,
   output logic spi_mosi,
   input  wire  spi_miso
);
   initial begin
      spi_sclk = 1'b0;
      spi_csn  = 1'b1;
      spi_mosi = 1'b0;
   end
   // ----------
   // Frame
   // ----------
   task automatic frame(input logic [15:0] w, input int nbits,
                        output logic [15:0] r);
      r = 16'h0000;
      #13 spi_csn = 1'b0;
      #400;
      for (int i = nbits - 1; i >= 0; i--) begin
         spi_mosi = w[i];
         #200 spi_sclk = 1'b1;
         #190 r = {r[14:0], spi_miso};
         #10 spi_sclk = 1'b0;
      end
      #200 spi_csn = 1'b1;
      // Released line must not keep showing the last bit
      spi_mosi = ~spi_mosi;
      #600;
   endtask
endmodule // odscl_spi_host

/* File: sim/odscl_core_tb_top.sv */
// Purpose: Self-checking bench for the SPI command logic
// Assumes: Fault stretch shortened to 20 cycles
// Notes:   Frames come from the host model; pins change on ref_clk
`timescale 1ns/10ps
module odscl_core_tb_top;
   localparam int STR = 20;
   logic        ref_clk = 1'b0;
   logic        resetn, spi_sclk, spi_csn, spi_mosi, spi_miso;
   logic        serial_setting_select, command_select, setup_select;
   logic        long_word_select, open_load_pin, check_error;
   logic [7:0]  in_pins, thermal_trip, open_load_det, above_7v;
   logic [7:0]  slow_mode, above_supply_flag, global_fault_in;
   logic [7:0]  short_circuit, high_switch, low_switch;
   logic [7:0]  pushpull_select, open_load_enable;
   logic [1:0]  watchdog_period, channel_coupling;
   logic        clock_count_error, fault_n;
   logic [15:0] rx;
   logic [7:0]  rv [0:3] = '{8'hA5, 8'h0F, 8'h3C, 8'h13};
   int          err_count = 0;
   int          samples_checked = 0;
   always #25 ref_clk = ~ref_clk;
   odscl_core #(.STRETCH_CYC(STR)) odscl_core_inst (
      .ref_clk, .resetn, .spi_sclk, .spi_csn, .spi_mosi, .spi_miso,
      .serial_setting_select, .command_select, .setup_select,
      .long_word_select, .open_load_pin, .in_pins, .thermal_trip,
      .open_load_det, .above_7v, .slow_mode, .above_supply_flag,
      .global_fault_in, .short_circuit, .check_error, .high_switch,
      .low_switch, .pushpull_select, .open_load_enable,
      .watchdog_period, .channel_coupling, .clock_count_error, .fault_n);
   odscl_spi_host odscl_spi_host_inst (
      .spi_sclk, .spi_csn, .spi_mosi, .spi_miso);
   // ----------
   // Tasks
   // ----------
   task automatic cyc(input int n);
      repeat (n) @(posedge ref_clk);
   endtask
   task automatic sx(input logic [15:0] w, input int n = 16);
      odscl_spi_host_inst.frame(w, n, rx);
   endtask
   task automatic chk_word(input logic [15:0] got, input logic [15:0] exp);
      samples_checked++;
      if (got !== exp) begin
         err_count++;
         $display("MISMATCH t=%0t got=%h exp=%h", $time, got, exp);
      end
   endtask
   task automatic chk_pin(input logic [7:0] got, input logic [7:0] exp);
      chk_word({8'h00, got}, {8'h00, exp});
   endtask
   task automatic results();
      $display("checks=%0d errors=%0d", samples_checked, err_count);
      if (err_count == 0 && samples_checked > 0) begin
         $display("All checks passed");
      end else begin
         $display("Checks failed");
      end
      $finish;
   endtask
   initial begin
      #1_000_000;
      err_count++;
      results();
   end
   // ----------
   // Sequence
   // ----------
   initial begin
      resetn = 1'b0;
      {serial_setting_select, command_select, setup_select} = 3'b110;
      {long_word_select, open_load_pin, check_error} = 3'b100;
      {in_pins, thermal_trip, open_load_det, global_fault_in} = 32'h0;
      {short_circuit, slow_mode} = 16'h00C3;
      above_7v = 8'h55;
      above_supply_flag = 8'h96;
      cyc(2);
      resetn <= 1'b1;
      cyc(5);
      chk_pin({7'h0, fault_n}, 8'h01);
      sx(16'h00A5);
      chk_pin(high_switch, 8'hA5);
      sx(16'h010F);
      chk_pin(pushpull_select, 8'h0F);
      chk_pin(low_switch, 8'h0A);
      sx(16'h023C);
      chk_pin(open_load_enable, 8'h3C);
      sx(16'h03F3);
      chk_pin({6'h0, watchdog_period}, 8'h03);
      sx(16'h2000);
      for (int n = 0; n < 4; n++) begin
         sx(16'h2001 + n[15:0]);
         chk_word(rx, {8'h00, rv[n]});
      end
      sx(16'h2007);
      chk_word(rx, 16'h0000);
      sx(16'h3000);
      chk_word(rx, {above_supply_flag, 8'h00});
      sx(16'h3000);
      chk_word(rx, {8'h00, above_7v});
      @(posedge ref_clk);
      thermal_trip <= 8'h81;
      open_load_det <= 8'h20;
      sx(16'h3000);
      sx(16'h3000);
      chk_word(rx, {8'hA1, above_7v});
      @(posedge ref_clk);
      thermal_trip <= 8'h00;
      open_load_det <= 8'h00;
      cyc(3 * STR);
      chk_pin({7'h0, fault_n}, 8'h00);
      sx(16'h2005);
      sx(16'h2004);
      chk_word(rx, 16'h0081);
      sx(16'h3000);
      chk_word(rx, 16'h0020);
      sx(16'hB000, 15);
      chk_pin({7'h0, clock_count_error}, 8'h01);
      sx(16'h2005);
      sx(16'h3000);
      chk_word(rx, 16'h0081);
      chk_pin({7'h0, clock_count_error}, 8'h00);
      sx(16'hB000);
      chk_pin({7'h0, fault_n}, 8'h01);
      sx(16'h2005);
      sx(16'h3000);
      chk_word(rx, 16'h0000);
      @(posedge ref_clk);
      command_select <= 1'b0;
      cyc(4);
      sx(16'h3C00);
      chk_pin(high_switch, 8'h3C);
      chk_pin(pushpull_select, 8'h00);
      @(posedge ref_clk);
      setup_select <= 1'b1;
      sx(16'h00FF);
      chk_pin(pushpull_select, 8'hFF);
      chk_pin(high_switch, 8'h3C);
      chk_pin(low_switch, 8'hC3);
      sx(16'hFF00);
      chk_pin(pushpull_select, 8'h00);
      chk_pin(open_load_enable, 8'hFF);
      @(posedge ref_clk);
      {serial_setting_select, command_select, setup_select} <= 3'b010;
      in_pins <= 8'h5A;
      cyc(4);
      sx(16'h00FF);
      chk_pin(high_switch, 8'h5A);
      sx(16'h2000);
      sx(16'h3000);
      chk_word(rx, 16'h00FF);
      results();
   end
endmodule // odscl_core_tb_top
